// ---- design/cfc_pkg.sv ----
// cfc_pkg: constants and types of the flow and condition-register unit
// assumes one execution state per ref_clk cycle and a word-wide memory
// Operation
// - jump loads pc from register, absolute word or indirect word; 4/6/8
// - relative call pushes pc at sp-2, adds signed displacement; 6 states
// - absolute call pushes pc at sp-2, loads target; 8 states
// - return pops pc from stack top, sp grows by two; 8 states
// - sleep enters low-power mode, flags untouched; 2 states
// - condition load replaces all flags; store copies it to a byte reg
// - and/or/xor immediate into condition register, write back; 2 states
// - block move copies byte at source to dest, bumps both pointers
// - block move counts down to zero; zero count just moves on
// - block move takes four states per byte plus nine
package cfc_pkg;
    typedef enum logic [4:0] {
        OP_JMP_REG = 5'h00, OP_JMP_ABS = 5'h01, OP_JMP_IND = 5'h02,
        OP_BSR     = 5'h03, OP_JSR_REG = 5'h04, OP_JSR_ABS = 5'h05,
        OP_JSR_IND = 5'h06, OP_RTS     = 5'h07, OP_RTE     = 5'h08,
        OP_SLEEP   = 5'h09, OP_LDC_IMM = 5'h0a, OP_LDC_REG = 5'h0b,
        OP_STC     = 5'h0c, OP_AND_COND_REG    = 5'h0d, OP_ORC     = 5'h0e,
        OP_XOR_COND_REG    = 5'h0f, OP_NOP     = 5'h10, OP_BMOVE   = 5'h11
    } cfc_op_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_MOVE = 3'b100
    } cfc_state_t;
    // execution states per instruction
    localparam logic [3:0] STATES_2  = 4'h2;
    localparam logic [3:0] STATES_4  = 4'h4;
    localparam logic [3:0] STATES_6  = 4'h6;
    localparam logic [3:0] STATES_8  = 4'h8;
    localparam logic [3:0] STATES_9  = 4'h9;
    localparam logic [3:0] STATES_10 = 4'ha;
    localparam logic [3:0] STEP_ONE  = 4'h1;
    // steps inside an instruction at which memory is used
    localparam logic [3:0] STEP_RD1  = 4'h0;
    localparam logic [3:0] STEP_RD2  = 4'h1;
    localparam logic [3:0] STEP_CAP1 = 4'h2;
    localparam logic [3:0] STEP_CAP2 = 4'h3;
    localparam logic [3:0] STEP_PUSH = 4'h2;
    // sub-steps of one moved byte
    localparam logic [1:0] MV_RD  = 2'h0;
    localparam logic [1:0] MV_WR  = 2'h2;
    localparam logic [1:0] MV_UPD = 2'h3;
    localparam logic [1:0] MV_ONE = 2'h1;
    // instruction lengths in bytes
    localparam logic [15:0] LEN_2 = 16'h0002;
    localparam logic [15:0] LEN_4 = 16'h0004;
    localparam logic [15:0] STACK_WORD = 16'h0002;
    localparam logic [15:0] RTE_FRAME  = 16'h0004;
    localparam logic [15:0] PTR_ONE    = 16'h0001;
    localparam logic [7:0]  CNT_ONE    = 8'h01;
    localparam logic [7:0]  CNT_ZERO   = 8'h00;
    localparam logic [7:0]  IND_PAGE   = 8'h00;
    localparam logic [7:0]  CCR_RESET  = 8'h80;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [15:0] WORD_ZERO  = 16'h0000;
endpackage

// ---- design/cfc_exec_unit.sv ----
// cfc_exec_unit: executes flow-control and condition-register instructions
// assumes a synchronous memory: read data valid the cycle after mem_rd
`timescale 1ns/1ps
`default_nettype none
module cfc_exec_unit (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire cfc_pkg::cfc_op_t op,
    input  wire logic [15:0]      opnd16,
    input  wire logic [7:0]       opnd8,
    output logic                  busy,
    output logic                  done,
    input  wire logic             arch_load,
    input  wire logic [15:0]      load_pc,
    input  wire logic [15:0]      load_sp,
    input  wire logic [15:0]      load_src,
    input  wire logic [15:0]      load_dst,
    input  wire logic [7:0]       load_cnt,
    input  wire logic [7:0]       load_ccr,
    output logic [15:0]           pc,
    output logic [15:0]           sp,
    output logic [15:0]           source_pointer_reg,
    output logic [15:0]           dest_pointer_reg,
    output logic [7:0]            byte_counter_reg,
    output logic [7:0]            condition_register,
    output logic [7:0]            reg_wdata,
    output logic                  reg_we,
    output logic                  sleep_mode,
    input  wire logic             wake,
    output logic [15:0]           mem_addr,
    output logic [15:0]           mem_wdata,
    output logic                  mem_rd,
    output logic                  mem_wr,
    output logic                  mem_word,
    input  wire logic [15:0]      mem_rdata
);
    import cfc_pkg::*;

    cfc_state_t  state, next_state;
    cfc_op_t     cur_op, next_cur_op;
    logic [3:0]  step, next_step, last_step;
    logic [1:0]  sub, next_sub;
    logic [15:0] arg16, next_arg16, tmp, next_tmp, ilen, ret_pc;
    logic [7:0]  arg8, next_arg8;
    logic [15:0] next_pc, next_sp, next_src, next_dst;
    logic [7:0]  next_cnt, next_ccr, next_reg_wdata;
    logic        next_done, next_reg_we, next_sleep;
    logic [15:0] next_mem_addr, next_mem_wdata;
    logic        next_mem_rd, next_mem_wr, next_mem_word;
    logic        wake_s1, wake_s2;

    assign busy = (state != ST_IDLE) | sleep_mode;
    assign ret_pc = pc + ilen;

    // wake pin is asynchronous: two flops before use
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else begin
            wake_s1 <= wake;
            wake_s2 <= wake_s1;
        end
    end

    // per-instruction state count and byte length
    always_comb begin
        last_step = STATES_2 - STEP_ONE;
        ilen = LEN_2;
        case (cur_op)
            OP_JMP_REG: last_step = STATES_4 - STEP_ONE;
            OP_JMP_ABS: begin
                last_step = STATES_6 - STEP_ONE;
                ilen = LEN_4;
            end
            OP_JMP_IND: last_step = STATES_8 - STEP_ONE;
            OP_BSR:     last_step = STATES_6 - STEP_ONE;
            OP_JSR_REG: last_step = STATES_6 - STEP_ONE;
            OP_JSR_ABS: begin
                last_step = STATES_8 - STEP_ONE;
                ilen = LEN_4;
            end
            OP_JSR_IND: last_step = STATES_8 - STEP_ONE;
            OP_RTS:     last_step = STATES_8 - STEP_ONE;
            OP_RTE:     last_step = STATES_10 - STEP_ONE;
            OP_BMOVE: begin
                last_step = STATES_9 - STEP_ONE;
                ilen = LEN_4;
            end
            default: last_step = STATES_2 - STEP_ONE;
        endcase
    end

    // sequencer: next values of all architectural and memory state
    always_comb begin
        next_state = state;
        next_cur_op = cur_op;
        next_step = step;
        next_sub = sub;
        next_arg16 = arg16;
        next_arg8 = arg8;
        next_tmp = tmp;
        next_pc = pc;
        next_sp = sp;
        next_src = source_pointer_reg;
        next_dst = dest_pointer_reg;
        next_cnt = byte_counter_reg;
        next_ccr = condition_register;
        next_reg_wdata = reg_wdata;
        next_reg_we = 1'b0;
        next_done = 1'b0;
        next_sleep = sleep_mode;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_mem_rd = 1'b0;
        next_mem_wr = 1'b0;
        next_mem_word = 1'b0;
        case (state)
            ST_IDLE: begin
                if (sleep_mode) begin
                    if (wake_s2) begin
                        next_sleep = 1'b0;
                    end
                end else if (start) begin
                    next_state = ST_EXEC;
                    next_cur_op = op;
                    next_arg16 = opnd16;
                    next_arg8 = opnd8;
                    next_step = STEP_RD1;
                end else if (arch_load) begin
                    next_pc = load_pc;
                    next_sp = load_sp;
                    next_src = load_src;
                    next_dst = load_dst;
                    next_cnt = load_cnt;
                    next_ccr = load_ccr;
                end
            end
            ST_EXEC: begin
                next_step = step + STEP_ONE;
                // first stack or indirect read
                if (step == STEP_RD1) begin
                    if (cur_op == OP_JMP_IND || cur_op == OP_JSR_IND) begin
                        next_mem_rd = 1'b1;
                        next_mem_word = 1'b1;
                        next_mem_addr = {IND_PAGE, arg8};
                    end else if (cur_op == OP_RTS || cur_op == OP_RTE) begin
                        next_mem_rd = 1'b1;
                        next_mem_word = 1'b1;
                        next_mem_addr = sp;
                    end
                end
                // second pop of the exception frame
                if (step == STEP_RD2 && cur_op == OP_RTE) begin
                    next_mem_rd = 1'b1;
                    next_mem_word = 1'b1;
                    next_mem_addr = sp + STACK_WORD;
                end
                if (step == STEP_CAP1) begin
                    next_tmp = mem_rdata;
                    next_arg8 = (cur_op == OP_RTE) ? mem_rdata[15:8] : arg8;
                end
                if (step == STEP_CAP2 && cur_op == OP_RTE) begin
                    next_tmp = mem_rdata;
                end
                // push return address below the stack top
                if (step == STEP_PUSH && (cur_op == OP_BSR ||
                    cur_op == OP_JSR_REG || cur_op == OP_JSR_ABS ||
                    cur_op == OP_JSR_IND)) begin
                    next_mem_wr = 1'b1;
                    next_mem_word = 1'b1;
                    next_mem_addr = sp - STACK_WORD;
                    next_mem_wdata = ret_pc;
                end
                if (step == last_step) begin
                    next_state = ST_IDLE;
                    next_done = 1'b1;
                    case (cur_op)
                        OP_JMP_REG, OP_JMP_ABS: next_pc = arg16;
                        OP_JMP_IND: next_pc = tmp;
                        OP_BSR: begin
                            next_sp = sp - STACK_WORD;
                            next_pc = ret_pc + 16'($signed(arg8));
                        end
                        OP_JSR_REG, OP_JSR_ABS: begin
                            next_sp = sp - STACK_WORD;
                            next_pc = arg16;
                        end
                        OP_JSR_IND: begin
                            next_sp = sp - STACK_WORD;
                            next_pc = tmp;
                        end
                        OP_RTS: begin
                            next_pc = tmp;
                            next_sp = sp + STACK_WORD;
                        end
                        OP_RTE: begin
                            next_ccr = arg8;
                            next_pc = tmp;
                            next_sp = sp + RTE_FRAME;
                        end
                        OP_SLEEP: begin
                            next_sleep = 1'b1;
                            next_pc = ret_pc;
                        end
                        OP_LDC_IMM, OP_LDC_REG: begin
                            next_ccr = arg8;
                            next_pc = ret_pc;
                        end
                        OP_STC: begin
                            next_reg_wdata = condition_register;
                            next_reg_we = 1'b1;
                            next_pc = ret_pc;
                        end
                        OP_AND_COND_REG: begin
                            next_ccr = condition_register & arg8;
                            next_pc = ret_pc;
                        end
                        OP_ORC: begin
                            next_ccr = condition_register | arg8;
                            next_pc = ret_pc;
                        end
                        OP_XOR_COND_REG: begin
                            next_ccr = condition_register ^ arg8;
                            next_pc = ret_pc;
                        end
                        OP_BMOVE: begin
                            if (byte_counter_reg == CNT_ZERO) begin
                                next_pc = ret_pc;
                            end else begin
                                next_state = ST_MOVE;
                                next_done = 1'b0;
                                next_sub = MV_RD;
                            end
                        end
                        default: next_pc = ret_pc;
                    endcase
                end
            end
            ST_MOVE: begin
                // four states per byte: read, wait, write, update
                next_sub = sub + MV_ONE;
                case (sub)
                    MV_RD: begin
                        next_mem_rd = 1'b1;
                        next_mem_addr = source_pointer_reg;
                    end
                    MV_WR: begin
                        next_mem_wr = 1'b1;
                        next_mem_addr = dest_pointer_reg;
                        next_mem_wdata = {BYTE_ZERO, mem_rdata[7:0]};
                    end
                    MV_UPD: begin
                        next_src = source_pointer_reg + PTR_ONE;
                        next_dst = dest_pointer_reg + PTR_ONE;
                        next_cnt = byte_counter_reg - CNT_ONE;
                        if (byte_counter_reg == CNT_ONE) begin
                            next_state = ST_IDLE;
                            next_done = 1'b1;
                            next_pc = ret_pc;
                        end
                    end
                    default: next_sub = sub + MV_ONE;
                endcase
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // registers of the sequencer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cur_op <= OP_NOP;
            step <= STEP_RD1;
            sub <= MV_RD;
            arg16 <= WORD_ZERO;
            arg8 <= BYTE_ZERO;
            tmp <= WORD_ZERO;
            pc <= WORD_ZERO;
            sp <= WORD_ZERO;
            source_pointer_reg <= WORD_ZERO;
            dest_pointer_reg <= WORD_ZERO;
            byte_counter_reg <= BYTE_ZERO;
            condition_register <= CCR_RESET;
            reg_wdata <= BYTE_ZERO;
            reg_we <= 1'b0;
            done <= 1'b0;
            sleep_mode <= 1'b0;
            mem_addr <= WORD_ZERO;
            mem_wdata <= WORD_ZERO;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_word <= 1'b0;
        end else begin
            state <= next_state;
            cur_op <= next_cur_op;
            step <= next_step;
            sub <= next_sub;
            arg16 <= next_arg16;
            arg8 <= next_arg8;
            tmp <= next_tmp;
            pc <= next_pc;
            sp <= next_sp;
            source_pointer_reg <= next_src;
            dest_pointer_reg <= next_dst;
            byte_counter_reg <= next_cnt;
            condition_register <= next_ccr;
            reg_wdata <= next_reg_wdata;
            reg_we <= next_reg_we;
            done <= next_done;
            sleep_mode <= next_sleep;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            mem_rd <= next_mem_rd;
            mem_wr <= next_mem_wr;
            mem_word <= next_mem_word;
        end
    end

    // checks on timing and effects of selected instructions
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_go(cfc_op_t o);
        state == ST_IDLE && !sleep_mode && start && op == o;
    endsequence
    sequence s_push_at(logic [15:0] a);
        mem_wr && mem_word && mem_addr == a;
    endsequence

    a_jump_reg: assert property (
        s_go(OP_JMP_REG) |-> ##5 done && pc == $past(opnd16, 5))
        else $error("register jump wrong");
    a_jump_ind_time: assert property (
        s_go(OP_JMP_IND) |-> ##1 !done [*8] ##1 done)
        else $error("indirect jump not 8 states");
    a_bsr_push: assert property (
        s_go(OP_BSR) |-> ##4 s_push_at($past(sp, 4) - STACK_WORD)
        ##3 done && sp == $past(sp, 7) - STACK_WORD)
        else $error("relative call push wrong");
    a_call_abs: assert property (
        s_go(OP_JSR_ABS) |-> ##9 done && pc == $past(opnd16, 9))
        else $error("absolute call wrong");
    a_return_pop: assert property (
        s_go(OP_RTS) |-> ##9 done && sp == $past(sp, 9) + STACK_WORD)
        else $error("return pop wrong");
    a_sleep_entry: assert property (
        s_go(OP_SLEEP) |-> ##3 done && sleep_mode &&
        condition_register == $past(condition_register, 3))
        else $error("sleep entry wrong");
    a_ccr_load: assert property (
        s_go(OP_LDC_IMM) |-> ##3 done &&
        condition_register == $past(opnd8, 3))
        else $error("condition load wrong");
    a_ccr_and: assert property (
        s_go(OP_AND_COND_REG) |-> ##3 done && condition_register ==
        ($past(condition_register, 3) & $past(opnd8, 3)))
        else $error("condition and wrong");
    a_move_update: assert property (
        state == ST_MOVE && sub == MV_UPD |=>
        source_pointer_reg == $past(source_pointer_reg) + PTR_ONE &&
        dest_pointer_reg == $past(dest_pointer_reg) + PTR_ONE)
        else $error("move pointers not bumped");
    a_move_zero: assert property (
        s_go(OP_BMOVE) ##0 byte_counter_reg == CNT_ZERO |->
        ##10 done && pc == $past(pc, 10) + LEN_4)
        else $error("empty move wrong");
    a_move_one: assert property (
        s_go(OP_BMOVE) ##0 byte_counter_reg == CNT_ONE |->
        ##14 done && byte_counter_reg == CNT_ZERO)
        else $error("one byte move not 13 states");
    a_exc_return: assert property (
        s_go(OP_RTE) |-> ##11 done && sp == $past(sp, 11) + RTE_FRAME)
        else $error("exception return wrong");
    a_nop_only: assert property (
        s_go(OP_NOP) |-> ##3 done && pc == $past(pc, 3) + LEN_2 &&
        sp == $past(sp, 3))
        else $error("no-operation wrong");
endmodule
`default_nettype wire

// ---- bench/cfc_mem_model.sv ----
// cfc_mem_model: byte memory standing in for program store and stack
// assumes registered one-cycle strobes; a word is high byte first
`timescale 1ns/1ps
`default_nettype none
module cfc_mem_model (
    input  wire logic        ref_clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic        mem_word,
    output logic [15:0]      mem_rdata
);
    logic [7:0] mem [0:65535];

    initial mem_rdata = 16'h5a5a;

    // writes land at the edge; read data is good for one cycle only
    always @(posedge ref_clk) begin
        if (mem_wr && mem_word) begin
            mem[mem_addr]            <= mem_wdata[15:8];
            mem[mem_addr + 16'h0001] <= mem_wdata[7:0];
        end else if (mem_wr) begin
            mem[mem_addr] <= mem_wdata[7:0];
        end
        if (mem_rd && mem_word)
            mem_rdata <= {mem[mem_addr], mem[mem_addr + 16'h0001]};
        else if (mem_rd)
            mem_rdata <= {~mem[mem_addr], mem[mem_addr]};
        else
            mem_rdata <= ~mem_rdata; // stale data never lingers
    end
endmodule
`default_nettype wire

// ---- bench/cpu_flow_control_and_ccr_ops_tb.sv ----
// cpu_flow_control_and_ccr_ops_tb: self-checking bench of the exec unit
// assumes cfc_pkg, cfc_exec_unit and cfc_mem_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module cpu_flow_control_and_ccr_ops_tb;
    import cfc_pkg::*;
    logic        ref_clk, rst_n, start, arch_load, wake;
    cfc_op_t     op;
    logic [15:0] opnd16, load_pc, load_sp, load_src, load_dst;
    logic [7:0]  opnd8, load_cnt, load_ccr;
    logic        busy, done, reg_we, sleep_mode, mem_rd, mem_wr, mem_word;
    logic [15:0] pc, sp, source_pointer_reg, dest_pointer_reg;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    logic [7:0]  byte_counter_reg, condition_register, reg_wdata;
    int          n_fail, checks_done;
    localparam cfc_op_t CC_OP [6] = '{OP_LDC_IMM, OP_AND_COND_REG, OP_ORC,
                                      OP_XOR_COND_REG, OP_LDC_REG, OP_NOP};
    localparam logic [7:0] CC_ARG [6] = '{8'hb3, 8'h0f, 8'h70,
                                          8'hff, 8'h21, 8'h00};
    localparam logic [7:0] CC_EXP [6] = '{8'hb3, 8'h03, 8'h73,
                                          8'h8c, 8'h21, 8'h21};

    cfc_exec_unit cfc_exec_unit_inst (
        .ref_clk, .rst_n, .start, .op, .opnd16, .opnd8, .busy, .done,
        .arch_load, .load_pc, .load_sp, .load_src, .load_dst, .load_cnt,
        .load_ccr, .pc, .sp, .source_pointer_reg, .dest_pointer_reg,
        .byte_counter_reg, .condition_register, .reg_wdata, .reg_we,
        .sleep_mode, .wake, .mem_addr, .mem_wdata, .mem_rd, .mem_wr,
        .mem_word, .mem_rdata
    );
    cfc_mem_model cfc_mem_model_inst (
        .ref_clk, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_word,
        .mem_rdata
    );

    // 10 MHz clock
    initial ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;

    // value compare, four-state exact
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    function automatic logic [15:0] get_w(input logic [15:0] a);
        return {cfc_mem_model_inst.mem[a],
                cfc_mem_model_inst.mem[a + 16'h0001]};
    endfunction

    task automatic put_w(input logic [15:0] a, input logic [15:0] d);
        cfc_mem_model_inst.mem[a] = d[15:8];
        cfc_mem_model_inst.mem[a + 16'h0001] = d[7:0];
    endtask

    // preset the architectural state in one idle edge
    task automatic preset(input logic [15:0] p, s, a, d,
                          input logic [7:0] c, f);
        @(posedge ref_clk);
        arch_load <= 1'b1;
        load_pc <= p;
        load_sp <= s;
        load_src <= a;
        load_dst <= d;
        load_cnt <= c;
        load_ccr <= f;
        @(posedge ref_clk);
        arch_load <= 1'b0;
    endtask

    // issue one instruction, count states to done; returns in done cycle
    task automatic exec(input cfc_op_t o, input logic [15:0] w,
                        input logic [7:0] b, input int n);
        int k;
        k = 0;
        @(posedge ref_clk);
        start <= 1'b1;
        op <= o;
        opnd16 <= w;
        opnd8 <= b;
        @(posedge ref_clk);
        start <= 1'b0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (done !== 1'b1 && k < 300);
        chk("states", 16'(n), 16'(k));
    endtask

    task automatic call_chk(input logic [15:0] p, s, r);
        chk("pc", p, pc);
        chk("sp", s, sp);
        chk("stacked pc", r, get_w(s));
    endtask

    task automatic t_reset();
        @(posedge ref_clk);
        #1;
        chk("pc", 16'h0000, pc);
        chk("ccr", {8'h00, CCR_RESET}, {8'h00, condition_register});
        chk("busy", 16'h0000, {15'h0000, busy});
        $display("reset test done");
    endtask

    task automatic t_jump();
        preset(16'h0100, 16'hff00, 16'h0000, 16'h0000, 8'h00, 8'h5a);
        exec(OP_JMP_REG, 16'h1234, 8'h00, 4);
        chk("pc", 16'h1234, pc);
        exec(OP_JMP_ABS, 16'h2000, 8'h00, 6);
        chk("pc", 16'h2000, pc);
        put_w(16'h0040, 16'h3456);
        exec(OP_JMP_IND, 16'h0000, 8'h40, 8);
        chk("pc", 16'h3456, pc);
        chk("ccr", 16'h005a, {8'h00, condition_register});
        $display("jump test done");
    endtask

    task automatic t_call();
        preset(16'h0200, 16'hff00, 16'h0000, 16'h0000, 8'h00, 8'h5a);
        exec(OP_BSR, 16'h0000, 8'hf0, 6);
        call_chk(16'h01f2, 16'hfefe, 16'h0202);
        exec(OP_JSR_REG, 16'h4000, 8'h00, 6);
        call_chk(16'h4000, 16'hfefc, 16'h01f4);
        exec(OP_JSR_ABS, 16'h5000, 8'h00, 8);
        call_chk(16'h5000, 16'hfefa, 16'h4004);
        put_w(16'h0080, 16'h6000);
        exec(OP_JSR_IND, 16'h0000, 8'h80, 8);
        call_chk(16'h6000, 16'hfef8, 16'h5002);
        exec(OP_RTS, 16'h0000, 8'h00, 8);
        chk("pc", 16'h5002, pc);
        chk("sp", 16'hfefa, sp);
        chk("ccr", 16'h005a, {8'h00, condition_register});
        $display("call test done");
    endtask

    task automatic t_rte();
        preset(16'h0300, 16'hfe00, 16'h0000, 16'h0000, 8'h00, 8'h00);
        put_w(16'hfe00, 16'ha500);
        put_w(16'hfe02, 16'h7000);
        exec(OP_RTE, 16'h0000, 8'h00, 10);
        chk("ccr", 16'h00a5, {8'h00, condition_register});
        chk("pc", 16'h7000, pc);
        chk("sp", 16'hfe04, sp);
        $display("exception return test done");
    endtask

    task automatic t_ccr();
        preset(16'h0400, 16'hfe00, 16'h0000, 16'h0000, 8'h00, 8'h00);
        for (int i = 0; i < 6; i++) begin
            exec(CC_OP[i], 16'h0000, CC_ARG[i], 2);
            chk("ccr", {8'h00, CC_EXP[i]},
                {8'h00, condition_register});
            chk("pc", 16'(16'h0402 + 2 * i), pc);
        end
        exec(OP_STC, 16'h0000, 8'h00, 2);
        chk("store strobe", 16'h0001, {15'h0000, reg_we});
        chk("store data", 16'h0021, {8'h00, reg_wdata});
        chk("ccr", 16'h0021, {8'h00, condition_register});
        $display("condition register test done");
    endtask

    task automatic t_sleep();
        preset(16'h0500, 16'hfe00, 16'h0000, 16'h0000, 8'h00, 8'h3c);
        exec(OP_SLEEP, 16'h0000, 8'h00, 2);
        chk("sleep", 16'h0001, {15'h0000, sleep_mode});
        chk("ccr", 16'h003c, {8'h00, condition_register});
        // a start while asleep must be ignored
        @(posedge ref_clk);
        start <= 1'b1;
        op <= OP_NOP;
        @(posedge ref_clk);
        start <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("busy", 16'h0001, {15'h0000, busy});
        chk("pc", 16'h0502, pc);
        @(posedge ref_clk);
        wake <= 1'b1;
        @(posedge ref_clk);
        wake <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("sleep", 16'h0000, {15'h0000, sleep_mode});
        $display("sleep test done");
    endtask

    task automatic t_move();
        preset(16'h0600, 16'hfe00, 16'h1000, 16'h2000, 8'h03, 8'h55);
        for (int i = 0; i < 4; i++) begin
            cfc_mem_model_inst.mem[16'h1000 + i] = 8'ha1 + 8'(17 * i);
            cfc_mem_model_inst.mem[16'h2000 + i] = 8'h00;
        end
        exec(OP_BMOVE, 16'h0000, 8'h00, 21);
        for (int i = 0; i < 3; i++)
            chk("moved byte", 16'(8'ha1 + 8'(17 * i)),
                {8'h00, cfc_mem_model_inst.mem[16'h2000 + i]});
        chk("past end", 16'h0000,
            {8'h00, cfc_mem_model_inst.mem[16'h2003]});
        chk("src", 16'h1003, source_pointer_reg);
        chk("dst", 16'h2003, dest_pointer_reg);
        chk("count", 16'h0000, {8'h00, byte_counter_reg});
        chk("pc", 16'h0604, pc);
        exec(OP_BMOVE, 16'h0000, 8'h00, 9);
        chk("pc", 16'h0608, pc);
        chk("src", 16'h1003, source_pointer_reg);
        chk("ccr", 16'h0055, {8'h00, condition_register});
        // a single byte: the shortest counted move
        preset(16'h0608, 16'hfe00, 16'h1003, 16'h2003, 8'h01, 8'h55);
        exec(OP_BMOVE, 16'h0000, 8'h00, 13);
        chk("moved byte", 16'h00d4,
            {8'h00, cfc_mem_model_inst.mem[16'h2003]});
        chk("pc", 16'h060c, pc);
        $display("block move test done");
    endtask

    // print counts and verdict, then stop
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        n_fail = 0;
        checks_done = 0;
        rst_n = 1'b0;
        start = 1'b0;
        op = OP_NOP;
        opnd16 = 16'h0000;
        opnd8 = 8'h00;
        arch_load = 1'b0;
        wake = 1'b0;
        {load_pc, load_sp, load_src, load_dst} = 64'h0;
        {load_cnt, load_ccr} = 16'h0000;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_jump();
        t_call();
        t_rte();
        t_ccr();
        t_sleep();
        t_move();
        finish_test();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
